// ### hw/tie_table_instruction_engine.sv
// Table and digit-rearrangement instruction execution engine
//
// Summary of operation
// [R01] Shuffle up to 8 digits: source from stack level 1, order from accumulator.
// [R02] Order digit zero or nine through F drops its source digit; result positions no order digit names read zero.
// [R03] Repeated destination takes the digit of the most significant duplicate.
// [R04] Order digit names result position, counted from one, receiving same-position digit.
// [R05] Copy: count stack 1, source accumulator, destination operand, consecutive words.
// [R06] Copy word count supplied no larger than hex 40.
// [R07] Copy raises range error when count exceeds what the engine handles.
// [R08] Label copy takes word count from stack level 2.
// [R09] Label copy adds stack-1 offset to both source and destination.
// [R10] Label copy source is accumulator label address, destination is operand.
// [R11] Bit set drives one addressed table bit to one, others unchanged.
// [R12] Bit clear drives one addressed table bit to zero, others unchanged.
// [R13] Bit ops: table length in stack 1 (0 to FF), start in accumulator.
// [R14] Bit numbers count from zero; each word holds 16 bits.
// [R15] Bit ops raise range error when bit lies past the table end.
// [R16] Flag valid until scan end or next flag-using instruction.
// [R17] Fill writes one value into every location of up to 255 words.
// [R18] Fill: count in stack 1 (0 to FF), start in accumulator.
// [R19] Search scans up to 255 words; parameters from stacks and accumulator.
// [R20] Search returns first match offset; none gives zero and range error.
// [R21] Instruction runs only when enabled; otherwise memory untouched.
`timescale 1ns/100ps
module tie_table_instruction_engine (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic enable,
  input wire tie_pkg::tie_cmd_type cmd,
  input wire logic scan_end,
  output logic [tie_pkg::AW-1:0] mem_addr,
  output logic mem_re,
  output logic mem_we,
  output logic [tie_pkg::DW-1:0] mem_wdata,
  input wire logic [tie_pkg::DW-1:0] mem_rdata,
  output logic [tie_pkg::AW-1:0] label_addr,
  output logic label_re,
  input wire logic [tie_pkg::DW-1:0] label_rdata,
  output logic [tie_pkg::ACCW-1:0] acc_out,
  output logic acc_we,
  output logic range_error_flag,
  output logic busy,
  output logic done
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [tie_pkg::ACCW-1:0] shuffle(
    input logic [tie_pkg::ACCW-1:0] src,
    input logic [tie_pkg::ACCW-1:0] order
  );
    logic [tie_pkg::ACCW-1:0] res;
    logic [3:0] d;
    logic [2:0] pos;
    res = '0;
    // Ascending walk lets the more significant duplicate overwrite the lower one
    for (int i = 0; i < tie_pkg::DIGITS; i++) begin // [R03]
      d = order[i*4 +: 4];
      pos = 3'(d - 4'h1);
      if (d != tie_pkg::DIGIT_NONE && d <= tie_pkg::DIGIT_MAX) begin // [R02]
        res[pos*4 +: 4] = src[i*4 +: 4]; // [R01] [R04]
      end
    end
    return res;
  endfunction

  function automatic logic [tie_pkg::DW-1:0] bit_mask(input logic [3:0] b);
    return tie_pkg::ONE16 << b;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tie_pkg::tie_regs_type s_r;
  tie_pkg::tie_regs_type s_nxt;

  logic [tie_pkg::AW-1:0] rd_addr;
  logic [tie_pkg::AW-1:0] wr_addr;
  logic last_word;
  logic [tie_pkg::AW-1:0] bit_limit;

  assign rd_addr = s_r.src + s_r.idx;
  assign wr_addr = s_r.dst + s_r.idx;
  assign last_word = (s_r.idx + tie_pkg::ONE16) >= s_r.cnt;
  assign bit_limit = {4'h0, cmd.stk1[7:0], 4'h0}; // [R13] [R14]

  always_comb begin
    s_nxt = s_r;
    s_nxt.acc_we = 1'b0;
    s_nxt.done = 1'b0;
    if (scan_end) begin
      s_nxt.flag = 1'b0; // [R16]
    end
    case (s_r.st)
      tie_pkg::ST_IDLE: begin
        if (start && !enable) begin
          s_nxt.done = 1'b1; // [R21]
        end else if (start) begin
          s_nxt.op = cmd.op;
          s_nxt.idx = tie_pkg::ZERO16;
          s_nxt.err = 1'b0;
          s_nxt.value = cmd.value;
          s_nxt.st = tie_pkg::ST_FIN;
          // A new flag-using instruction invalidates the previous outcome
          if (cmd.op != tie_pkg::OP_SHUFFLE) begin
            s_nxt.flag = 1'b0; // [R16]
          end
          case (cmd.op)
            tie_pkg::OP_SHUFFLE: begin
              s_nxt.acc = shuffle(cmd.stk1, cmd.acc); // [R01]
            end
            tie_pkg::OP_COPY: begin
              s_nxt.cnt = cmd.stk1[15:0]; // [R05]
              s_nxt.src = cmd.acc[15:0];
              s_nxt.dst = cmd.operand;
              if (cmd.stk1 > tie_pkg::COPY_MAX) begin
                s_nxt.err = 1'b1; // [R07]
              end else if (cmd.stk1[15:0] != tie_pkg::ZERO16) begin
                s_nxt.st = tie_pkg::ST_RD;
              end
            end
            tie_pkg::OP_LABEL: begin
              s_nxt.cnt = cmd.stk2[15:0]; // [R08]
              s_nxt.src = cmd.acc[15:0] + cmd.stk1[15:0]; // [R09] [R10]
              s_nxt.dst = cmd.operand + cmd.stk1[15:0]; // [R09] [R10]
              if (cmd.stk2[15:0] != tie_pkg::ZERO16) begin
                s_nxt.st = tie_pkg::ST_RD;
              end
            end
            tie_pkg::OP_BIT_ONE, tie_pkg::OP_BIT_ZERO: begin
              s_nxt.cnt = tie_pkg::ONE16;
              s_nxt.src = cmd.acc[15:0] + (cmd.operand >> tie_pkg::WORD_SHIFT); // [R14]
              s_nxt.dst = cmd.acc[15:0] + (cmd.operand >> tie_pkg::WORD_SHIFT);
              s_nxt.bitpos = cmd.operand[3:0];
              if (cmd.operand >= bit_limit) begin
                s_nxt.err = 1'b1; // [R15]
              end else begin
                s_nxt.st = tie_pkg::ST_RD;
              end
            end
            tie_pkg::OP_FILL: begin
              s_nxt.cnt = {8'h00, cmd.stk1[7:0]}; // [R17] [R18]
              s_nxt.dst = cmd.acc[15:0];
              if (cmd.stk1[7:0] != 8'h00) begin
                s_nxt.st = tie_pkg::ST_WR;
              end
            end
            tie_pkg::OP_FIND: begin
              s_nxt.cnt = {8'h00, cmd.stk2[7:0]}; // [R19]
              s_nxt.src = cmd.stk1[15:0];
              s_nxt.idx = cmd.acc[15:0];
              s_nxt.acc = '0;
              if (cmd.acc[15:0] >= {8'h00, cmd.stk2[7:0]}) begin
                s_nxt.err = 1'b1; // [R20]
              end else begin
                s_nxt.st = tie_pkg::ST_RD;
              end
            end
            default: begin
              s_nxt.st = tie_pkg::ST_FIN;
            end
          endcase
        end
      end
      tie_pkg::ST_RD: begin
        s_nxt.st = tie_pkg::ST_WR;
      end
      tie_pkg::ST_WR: begin
        s_nxt.idx = s_r.idx + tie_pkg::ONE16;
        if (s_r.op == tie_pkg::OP_FIND) begin
          if (mem_rdata == s_r.value) begin
            s_nxt.acc = {16'h0000, s_r.idx}; // [R20]
            s_nxt.st = tie_pkg::ST_FIN;
          end else if (last_word) begin
            s_nxt.acc = '0; // [R20]
            s_nxt.err = 1'b1;
            s_nxt.st = tie_pkg::ST_FIN;
          end else begin
            s_nxt.st = tie_pkg::ST_RD;
          end
        end else if (last_word) begin
          s_nxt.st = tie_pkg::ST_FIN;
        end else if (s_r.op == tie_pkg::OP_FILL) begin
          s_nxt.st = tie_pkg::ST_WR; // [R17]
        end else begin
          s_nxt.st = tie_pkg::ST_RD;
        end
      end
      tie_pkg::ST_FIN: begin
        s_nxt.done = 1'b1;
        s_nxt.acc_we = (s_r.op == tie_pkg::OP_SHUFFLE) || (s_r.op == tie_pkg::OP_FIND);
        // Set is applied after the scan-end clear so a same-cycle error survives
        s_nxt.flag = s_nxt.flag | s_r.err; // [R16]
        s_nxt.st = tie_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st = tie_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r.st <= tie_pkg::ST_IDLE;
      s_r.op <= tie_pkg::OP_SHUFFLE;
      s_r.cnt <= '0;
      s_r.idx <= '0;
      s_r.src <= '0;
      s_r.dst <= '0;
      s_r.value <= '0;
      s_r.bitpos <= '0;
      s_r.err <= 1'b0;
      s_r.flag <= 1'b0;
      s_r.acc <= '0;
      s_r.acc_we <= 1'b0;
      s_r.done <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Memory ports
  // ----------------------------------------------------------------
  // Except for fill, write data follows the one-cycle read latency, so it is built from read data: passed through for the copies, masked for bit set and clear
  always_comb begin
    mem_re = (s_r.st == tie_pkg::ST_RD) && (s_r.op != tie_pkg::OP_LABEL);
    label_re = (s_r.st == tie_pkg::ST_RD) && (s_r.op == tie_pkg::OP_LABEL);
    label_addr = rd_addr;
    mem_we = (s_r.st == tie_pkg::ST_WR) && (s_r.op != tie_pkg::OP_FIND); // [R21]
    mem_addr = (s_r.st == tie_pkg::ST_RD) ? rd_addr : wr_addr;
    case (s_r.op)
      tie_pkg::OP_COPY: mem_wdata = mem_rdata; // [R05]
      tie_pkg::OP_LABEL: mem_wdata = label_rdata; // [R10]
      tie_pkg::OP_BIT_ONE: mem_wdata = mem_rdata | bit_mask(s_r.bitpos); // [R11]
      tie_pkg::OP_BIT_ZERO: mem_wdata = mem_rdata & ~bit_mask(s_r.bitpos); // [R12]
      tie_pkg::OP_FILL: mem_wdata = s_r.value; // [R17]
      default: mem_wdata = '0;
    endcase
  end

  assign acc_out = s_r.acc;
  assign acc_we = s_r.acc_we;
  assign range_error_flag = s_r.flag;
  assign busy = (s_r.st != tie_pkg::ST_IDLE);
  assign done = s_r.done;

endmodule

// ### hw/tie_pkg.sv
// Package: constants, opcodes, carriers and state layout of the table instruction engine
package tie_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int AW = 16;
  localparam int ACCW = 32;
  localparam int DIGITS = 8;
  localparam logic [3:0] DIGIT_MAX = 4'h8;
  localparam logic [3:0] DIGIT_NONE = 4'h0;
  localparam logic [31:0] COPY_MAX = 32'h0000_0040;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam int WORD_SHIFT = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD = 4'h2,
    ST_WR = 4'h4,
    ST_FIN = 4'h8
  } tie_state_type;

  typedef enum logic [2:0] {
    OP_SHUFFLE = 3'h0,
    OP_COPY = 3'h1,
    OP_LABEL = 3'h2,
    OP_BIT_ONE = 3'h3,
    OP_BIT_ZERO = 3'h4,
    OP_FILL = 3'h5,
    OP_FIND = 3'h6
  } tie_op_type;

  typedef struct packed {
    tie_op_type op;
    logic [ACCW-1:0] acc;
    logic [ACCW-1:0] stk1;
    logic [ACCW-1:0] stk2;
    logic [AW-1:0] operand;
    logic [DW-1:0] value;
  } tie_cmd_type;

  typedef struct packed {
    tie_state_type st;
    tie_op_type op;
    logic [AW-1:0] cnt;
    logic [AW-1:0] idx;
    logic [AW-1:0] src;
    logic [AW-1:0] dst;
    logic [DW-1:0] value;
    logic [3:0] bitpos;
    logic err;
    logic flag;
    logic [ACCW-1:0] acc;
    logic acc_we;
    logic done;
  } tie_regs_type;

endpackage

// ### sim/tie_table_instruction_engine_chk.sv
// Checker for the table instruction engine ports
`timescale 1ns/100ps
module tie_table_instruction_engine_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic enable,
  input wire tie_pkg::tie_cmd_type cmd,
  input wire logic scan_end,
  input wire logic [15:0] mem_addr,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic label_re,
  input wire logic [15:0] label_rdata,
  input wire logic acc_we,
  input wire logic range_error_flag,
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Op tracking: cmd is only meaningful at the accepted start
  // ----------------------------------------------------------------
  tie_pkg::tie_op_type op_r;
  logic [15:0] val_r;
  logic go;
  assign go = start && !busy && enable;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_r <= tie_pkg::OP_SHUFFLE;
      val_r <= 16'h0000;
    end else if (go) begin
      op_r <= cmd.op;
      val_r <= cmd.value;
    end
  end
  sequence s_fin_we; done && acc_we; endsequence
  sequence s_quiet; !mem_we && !mem_re && !label_re; endsequence
  property p_skip; start && !busy && !enable |=> done and s_quiet; endproperty
  property p_shuffle; go && cmd.op == tie_pkg::OP_SHUFFLE |=> !mem_we ##1 s_fin_we; endproperty
  property p_copy_err;
    go && cmd.op == tie_pkg::OP_COPY && cmd.stk1 > tie_pkg::COPY_MAX
      |=> s_quiet ##1 done ##[0:1] range_error_flag;
  endproperty
  property p_scan; scan_end && !busy && !start |=> !range_error_flag; endproperty
  property p_copy;
    op_r == tie_pkg::OP_COPY && mem_re |=> mem_we && mem_wdata == mem_rdata;
  endproperty
  property p_label; label_re |=> mem_we && mem_wdata == label_rdata; endproperty
  property p_one;
    op_r == tie_pkg::OP_BIT_ONE && mem_we
      |-> (mem_wdata & mem_rdata) == mem_rdata && $countones(mem_wdata ^ mem_rdata) <= 1;
  endproperty
  property p_zero;
    op_r == tie_pkg::OP_BIT_ZERO && mem_we
      |-> (mem_wdata | mem_rdata) == mem_rdata && $countones(mem_wdata ^ mem_rdata) <= 1;
  endproperty
  property p_fill;
    op_r == tie_pkg::OP_FILL && mem_we
      |-> mem_wdata == val_r && (!$past(mem_we) || mem_addr == $past(mem_addr) + 16'h0001);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped op touched memory");
  a_shuffle: assert property (p_shuffle) else $error("shuffle answer late");
  a_copy_err: assert property (p_copy_err) else $error("copy overrun not flagged");
  a_scan: assert property (p_scan) else $error("flag survived scan end");
  a_copy: assert property (p_copy) else $error("copy data mismatch");
  a_label: assert property (p_label) else $error("label copy data mismatch");
  a_one: assert property (p_one) else $error("bit set changed wrong bits");
  a_zero: assert property (p_zero) else $error("bit clear changed wrong bits");
  a_fill: assert property (p_fill) else $error("fill value or address wrong");
endmodule
bind tie_table_instruction_engine tie_table_instruction_engine_chk tie_table_instruction_engine_chk_inst (
  .core_clk, .rst, .start, .enable, .cmd, .scan_end, .mem_addr, .mem_re, .mem_we, .mem_wdata,
  .mem_rdata, .label_re, .label_rdata, .acc_we, .range_error_flag, .busy, .done);

// ### sim/tb_table_instruction_engine.sv
// Self-checking testbench for the table instruction engine
`timescale 1ns/100ps
module tb_table_instruction_engine;
  logic core_clk, rst, start, enable, scan_end, mem_re, mem_we, label_re, acc_we, busy, done;
  logic range_error_flag, we_seen;
  tie_pkg::tie_cmd_type cmd;
  logic [15:0] mem_addr, mem_wdata, label_addr;
  logic [15:0] mem_rdata = 16'h0000;
  logic [15:0] label_rdata = 16'h0000;
  logic [31:0] acc_out;
  logic [15:0] mem [256];
  logic [15:0] lbl [256];
  int errors = 0;
  int checked = 0;
  tie_table_instruction_engine tie_table_instruction_engine_inst (.core_clk, .rst, .start,
    .enable, .cmd, .scan_end, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata, .label_addr,
    .label_re, .label_rdata, .acc_out, .acc_we, .range_error_flag, .busy, .done);
  // ----------------------------------------------------------------
  // Memories: one-cycle read latency, stale data inverted when idle
  // ----------------------------------------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr[7:0]] : ~mem_rdata;
    label_rdata <= label_re ? lbl[label_addr[7:0]] : ~label_rdata;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic issue(input tie_pkg::tie_op_type op, input logic [31:0] a, input logic [31:0] s1,
      input logic [31:0] s2, input logic [15:0] opd, input logic [15:0] val, input logic en);
    int n;
    cmd = '{op, a, s1, s2, opd, val};
    enable = en;
    start = 1'b1;
    @(posedge core_clk);
    #2 start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      #2 n++;
    end
    if (n == 600) errors++;
    we_seen = acc_we;
    // One spare cycle follows done; the registered flag is already valid in the done cycle
    @(posedge core_clk);
    #2;
  endtask
  function automatic logic [31:0] shuf(input logic [31:0] s, input logic [31:0] o);
    logic [31:0] r;
    logic [3:0] d;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      d = o[4*i+:4];
      if (d != 4'h0 && d < 4'h9) r[4*(int'(d)-1)+:4] = s[4*i+:4];
    end
    return r;
  endfunction
  task automatic t_shuffle();
    logic [31:0] ords [3] = '{32'h12345678, 32'h09F13355, 32'h00000000};
    for (int i = 0; i < 3; i++) begin
      issue(tie_pkg::OP_SHUFFLE, ords[i], 32'h87654321, '0, '0, '0, 1'b1);
      chk(acc_out, shuf(32'h87654321, ords[i]));
      chk(we_seen, 1);
    end
  endtask
  task automatic t_copy();
    issue(tie_pkg::OP_COPY, '0, 32'h40, '0, 16'h0080, '0, 1'b1);
    for (int i = 0; i < 64; i++) chk(mem[128+i], 16'hA500 + i);
    chk(mem[192], 16'hA5C0);
    chk(range_error_flag, 0);
    issue(tie_pkg::OP_COPY, '0, 32'h41, '0, 16'h00C0, '0, 1'b1);
    chk(range_error_flag, 1);
    chk(mem[192], 16'hA5C0);
    issue(tie_pkg::OP_LABEL, 32'h10, 32'h2, 32'h3, 16'h0040, '0, 1'b1);
    for (int i = 0; i < 3; i++) chk(mem[66+i], 16'hC312 + i);
    chk(mem[65], 16'hA541);
    chk(mem[69], 16'hA545);
  endtask
  task automatic t_bits();
    issue(tie_pkg::OP_BIT_ONE, 32'h20, 32'h2, '0, 16'h001C, '0, 1'b1);
    chk(mem[33], 16'hB521);
    issue(tie_pkg::OP_BIT_ZERO, 32'h20, 32'h2, '0, 16'h0005, '0, 1'b1);
    chk(mem[32], 16'hA500);
    issue(tie_pkg::OP_BIT_ZERO, 32'h20, 32'h2, '0, 16'h001F, '0, 1'b1);
    chk(mem[33], 16'h3521);
    chk(range_error_flag, 0);
    issue(tie_pkg::OP_BIT_ONE, 32'h20, 32'h2, '0, 16'h0020, '0, 1'b1);
    chk(range_error_flag, 1);
    chk(mem[34], 16'hA522);
    scan_end = 1'b1;
    @(posedge core_clk);
    #2 scan_end = 1'b0;
    @(posedge core_clk);
    #2 chk(range_error_flag, 0);
  endtask
  task automatic t_fill_find();
    issue(tie_pkg::OP_FILL, 32'h30, 32'h3, '0, '0, 16'hBEEF, 1'b1);
    for (int i = 0; i < 3; i++) chk(mem[48+i], 16'hBEEF);
    chk(mem[51], 16'hA533);
    issue(tie_pkg::OP_FILL, 32'h30, 32'h4, '0, '0, 16'h1234, 1'b0);
    chk(mem[48], 16'hBEEF);
    chk(mem[51], 16'hA533);
    issue(tie_pkg::OP_FIND, 32'h1, 32'h30, 32'h4, '0, 16'hA533, 1'b1);
    chk(acc_out, 32'h3);
    chk(range_error_flag, 0);
    chk(we_seen, 1);
    // Start offset at the table length is outside the table
    issue(tie_pkg::OP_FIND, 32'h4, 32'h30, 32'h4, '0, 16'hA533, 1'b1);
    chk(acc_out, 32'h0);
    chk(range_error_flag, 1);
    issue(tie_pkg::OP_FIND, 32'h1, 32'h30, 32'h4, '0, 16'h1234, 1'b1);
    chk(acc_out, 32'h0);
    chk(range_error_flag, 1);
  endtask
  // Scan end held across a failing copy: the error set must win over the clear
  task automatic t_flag_race();
    cmd = '{tie_pkg::OP_COPY, 32'h0, 32'h41, 32'h0, 16'h00C0, 16'h0000};
    enable = 1'b1;
    start = 1'b1;
    scan_end = 1'b1;
    @(posedge core_clk);
    #2 start = 1'b0;
    chk(busy, 1);
    chk(range_error_flag, 0);
    @(posedge core_clk);
    #2 scan_end = 1'b0;
    chk(done, 1);
    chk(range_error_flag, 1);
    chk(busy, 0);
    @(posedge core_clk);
    #2;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    enable = 1'b0;
    scan_end = 1'b0;
    cmd = '0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hA500 + 16'(i);
      lbl[i] = 16'hC300 + 16'(i);
    end
    repeat (10) @(posedge core_clk);
    #2 rst = 1'b0;
    t_shuffle();
    t_copy();
    t_bits();
    t_fill_find();
    t_flag_race();
    summarize();
  end
endmodule
